// ==== bcdalu_params.svh ====
// Register offsets, field positions, reset values and constants of the decimal unit
`ifndef BCDALU_PARAMS_SVH
`define BCDALU_PARAMS_SVH

// ==========================================================
// Register byte offsets
`define BCDALU_OFF_OPA 8'h00
`define BCDALU_OFF_OPB 8'h04
`define BCDALU_OFF_PTRA 8'h08
`define BCDALU_OFF_PTRB 8'h0C
`define BCDALU_OFF_CMD 8'h10
`define BCDALU_OFF_RES0 8'h14
`define BCDALU_OFF_RES1 8'h18
`define BCDALU_OFF_STAT 8'h1C

// ==========================================================
// Command word fields
`define BCDALU_CMD_OP_MSB 2
`define BCDALU_CMD_OP_LSB 0
`define BCDALU_CMD_DIFF 3
`define BCDALU_CMD_EXEC 4
`define BCDALU_CMD_AREA_MSB 7
`define BCDALU_CMD_AREA_LSB 5
`define BCDALU_CMD_IND_A 8
`define BCDALU_CMD_IND_B 9

// ==========================================================
// Status word fields
`define BCDALU_STAT_CY 0
`define BCDALU_STAT_ER 1
`define BCDALU_STAT_EQ 2
`define BCDALU_STAT_BUSY 3
`define BCDALU_STAT_ADDR_LSB 16

// ==========================================================
// Values
`define BCDALU_WORD_RST 16'h0000
`define BCDALU_SUB_BIAS 15'd10000
`define BCDALU_MUL_LIMIT 27'd100000000
`define BCDALU_CARRY_ADDR 16'd25504
`define BCDALU_DM_WORDS 14'd1000

`endif

// ==== bcdalu_pkg.sv ====
// Types shared by the decimal arithmetic unit
package bcdalu_pkg;

	// ==========================================================
	// Operations
	typedef enum logic [2:0] {
		BCDALU_NOP = 3'b000,
		BCDALU_SUB = 3'b001,
		BCDALU_MUL = 3'b010,
		BCDALU_DIV = 3'b011,
		BCDALU_CLC = 3'b100,
		BCDALU_STC = 3'b101
	} bcdalu_op_t;

	// ==========================================================
	// Data areas of an operand or result word
	typedef enum logic [2:0] {
		BCDALU_A_INT = 3'b000,
		BCDALU_A_SYS = 3'b001,
		BCDALU_A_AUX = 3'b010,
		BCDALU_A_DM = 3'b011,
		BCDALU_A_HOLD = 3'b100,
		BCDALU_A_TIM = 3'b101,
		BCDALU_A_LINK = 3'b110,
		BCDALU_A_IMM = 3'b111
	} bcdalu_area_t;

	// ==========================================================
	// Sequencer states
	typedef enum logic [0:0] {
		BCDALU_IDLE = 1'b0,
		BCDALU_RUN = 1'b1
	} bcdalu_state_t;

endpackage : bcdalu_pkg

// ==== bcdalu_b2d.sv ====
// Binary to packed decimal converter
`timescale 1ns/1ps

module bcdalu_b2d #(
	parameter int BITS = 14,
	parameter int DIGITS = 4
) (
	// Binary value in
	input wire logic [BITS-1:0] bin_i,
	// Packed digits out, least significant digit lowest
	output logic [4*DIGITS-1:0] bcd_o
);

	logic [4*DIGITS-1:0] acc;

	// Shift-and-add-three; input must fit the digit count
	always_comb begin
		acc = '0;
		for (int i = BITS - 1; i >= 0; i--) begin
			for (int d = 0; d < DIGITS; d++) begin
				if (acc[4*d+:4] >= 4'h5) begin
					acc[4*d+:4] = acc[4*d+:4] + 4'h3;
				end
			end
			acc = {acc[4*DIGITS-2:0], bin_i[i]};
		end
		bcd_o = acc;
	end

endmodule : bcdalu_b2d

// ==== bcdalu_top.sv ====
// Decimal subtract, multiply and divide unit with an APB register port
//
// Contract
// - When enabled, subtract gives minuend minus subtrahend minus carry into result word.
// - Subtraction is 10000 plus minuend less subtrahend and carry; top digit dropped.
// - Negative difference sets carry and stores the ten's complement.
// - Carry after subtract is on exactly when minuend < subtrahend plus carry.
// - Non-decimal subtract operand sets fault and produces no result.
// - Zero-result flag follows whether the result of sub, mul or div is zero.
// - Indirect pointer not decimal or past data-memory end raises fault.
// - Differentiated form runs once per false-to-true change of its condition.
// - Multiply writes eight-digit product, low half first word, high half next.
// - Non-decimal multiply operand raises fault.
// - Carry turns on when the product produces a carry.
// - Divide with false condition does nothing; control moves on.
// - Divide writes quotient to first word, remainder to next word.
// - Results may go only to internal, auxiliary, data-memory, holding or link areas.
// - Carry is the shared system-flag bit at address 25504.
// - Non-decimal dividend or divisor raises fault.
`timescale 1ns/1ps
`include "bcdalu_params.svh"

module bcdalu_top #(
	parameter logic [13:0] DM_WORDS = `BCDALU_DM_WORDS
) (
	// Clock and reset
	input wire logic CLK_I,
	input wire logic RST_I,
	// APB slave
	input wire logic PSEL_I,
	input wire logic PENABLE_I,
	input wire logic PWRITE_I,
	input wire logic [7:0] PADDR_I,
	input wire logic [31:0] PWDATA_I,
	output logic [31:0] PRDATA_O,
	output logic PREADY_O,
	output logic PSLVERR_O,
	// Result words toward the data areas
	output logic RES_WE_O,
	output logic RES_TWO_O,
	output logic [2:0] RES_AREA_O,
	output logic [15:0] RES_LO_O,
	output logic [15:0] RES_HI_O,
	// Flags
	output logic CARRY_O,
	output logic FAULT_O,
	output logic ZERO_O
);

	// ==========================================================
	// Decimal helpers
	function automatic logic is_bcd(input logic [15:0] w);
		logic ok;
		ok = 1'b1;
		for (int n = 0; n < 4; n++) begin
			if (w[4*n+:4] > 4'h9) begin
				ok = 1'b0;
			end
		end
		return ok;
	endfunction : is_bcd

	function automatic logic [13:0] bcd2bin(input logic [15:0] w);
		return 14'(w[15:12]) * 14'd1000 + 14'(w[11:8]) * 14'd100
			+ 14'(w[7:4]) * 14'd10 + 14'(w[3:0]);
	endfunction : bcd2bin

	// ==========================================================
	// Register state
	logic pready_r, pslverr_r;
	logic [31:0] prdata_r;
	logic [15:0] opa_r, opb_r, ptra_r, ptrb_r, res0_r, res1_r;
	bcdalu_pkg::bcdalu_op_t op_r;
	bcdalu_pkg::bcdalu_area_t area_r;
	bcdalu_pkg::bcdalu_state_t state_r, state_nxt;
	logic diff_r, exec_r, inda_r, indb_r, prev_exec_r;
	logic we_r, two_r, carry_r, fault_r, zero_r;
	logic [2:0] res_area_r;

	// ==========================================================
	// APB access
	logic acc_w, wr_w, hit_nxt;
	logic [31:0] rd_nxt;

	assign acc_w = PSEL_I & PENABLE_I;
	assign wr_w = acc_w & pready_r & PWRITE_I;

	always_comb begin
		hit_nxt = 1'b1;
		rd_nxt = 32'h00000000;
		case (PADDR_I)
			`BCDALU_OFF_OPA: rd_nxt[15:0] = opa_r;
			`BCDALU_OFF_OPB: rd_nxt[15:0] = opb_r;
			`BCDALU_OFF_PTRA: rd_nxt[15:0] = ptra_r;
			`BCDALU_OFF_PTRB: rd_nxt[15:0] = ptrb_r;
			`BCDALU_OFF_CMD: begin
				rd_nxt[`BCDALU_CMD_OP_MSB:`BCDALU_CMD_OP_LSB] = op_r;
				rd_nxt[`BCDALU_CMD_DIFF] = diff_r;
				rd_nxt[`BCDALU_CMD_EXEC] = exec_r;
				rd_nxt[`BCDALU_CMD_AREA_MSB:`BCDALU_CMD_AREA_LSB] = area_r;
				rd_nxt[`BCDALU_CMD_IND_A] = inda_r;
				rd_nxt[`BCDALU_CMD_IND_B] = indb_r;
			end
			`BCDALU_OFF_RES0: rd_nxt[15:0] = res0_r;
			`BCDALU_OFF_RES1: rd_nxt[15:0] = res1_r;
			`BCDALU_OFF_STAT: begin
				rd_nxt[`BCDALU_STAT_CY] = carry_r;
				rd_nxt[`BCDALU_STAT_ER] = fault_r;
				rd_nxt[`BCDALU_STAT_EQ] = zero_r;
				rd_nxt[`BCDALU_STAT_BUSY] = (state_r == bcdalu_pkg::BCDALU_RUN);
				rd_nxt[31:`BCDALU_STAT_ADDR_LSB] = `BCDALU_CARRY_ADDR;
			end
			default: hit_nxt = 1'b0;
		endcase
	end

	// One wait state so that read data and error come from flip-flops
	always_ff @(posedge CLK_I or posedge RST_I) begin
		if (RST_I) begin
			pready_r <= 1'b0;
			pslverr_r <= 1'b0;
			prdata_r <= 32'h00000000;
		end else begin
			pready_r <= acc_w & ~pready_r;
			if (acc_w & ~pready_r) begin
				pslverr_r <= ~hit_nxt;
				prdata_r <= PWRITE_I ? 32'h00000000 : rd_nxt;
			end else begin
				pslverr_r <= 1'b0;
			end
		end
	end

	// ==========================================================
	// Software-written registers
	always_ff @(posedge CLK_I or posedge RST_I) begin
		if (RST_I) begin
			opa_r <= `BCDALU_WORD_RST;
			opb_r <= `BCDALU_WORD_RST;
			ptra_r <= `BCDALU_WORD_RST;
			ptrb_r <= `BCDALU_WORD_RST;
			op_r <= bcdalu_pkg::BCDALU_NOP;
			area_r <= bcdalu_pkg::BCDALU_A_INT;
			diff_r <= 1'b0;
			exec_r <= 1'b0;
			inda_r <= 1'b0;
			indb_r <= 1'b0;
		end else if (wr_w) begin
			case (PADDR_I)
				`BCDALU_OFF_OPA: opa_r <= PWDATA_I[15:0];
				`BCDALU_OFF_OPB: opb_r <= PWDATA_I[15:0];
				`BCDALU_OFF_PTRA: ptra_r <= PWDATA_I[15:0];
				`BCDALU_OFF_PTRB: ptrb_r <= PWDATA_I[15:0];
				`BCDALU_OFF_CMD: begin
					op_r <= bcdalu_pkg::bcdalu_op_t'(
						PWDATA_I[`BCDALU_CMD_OP_MSB:`BCDALU_CMD_OP_LSB]);
					area_r <= bcdalu_pkg::bcdalu_area_t'(
						PWDATA_I[`BCDALU_CMD_AREA_MSB:`BCDALU_CMD_AREA_LSB]);
					diff_r <= PWDATA_I[`BCDALU_CMD_DIFF];
					exec_r <= PWDATA_I[`BCDALU_CMD_EXEC];
					inda_r <= PWDATA_I[`BCDALU_CMD_IND_A];
					indb_r <= PWDATA_I[`BCDALU_CMD_IND_B];
				end
				default: ;
			endcase
		end
	end

	// ==========================================================
	// Sequencer: each command write is one scan of the instruction
	logic cmd_wr_w, go_w, run_w;

	assign cmd_wr_w = wr_w & (PADDR_I == `BCDALU_OFF_CMD);
	assign go_w = (state_r == bcdalu_pkg::BCDALU_RUN);
	assign run_w = go_w & exec_r & (~diff_r | ~prev_exec_r);

	always_comb begin
		case (state_r)
			bcdalu_pkg::BCDALU_IDLE: state_nxt = cmd_wr_w ? bcdalu_pkg::BCDALU_RUN
				: bcdalu_pkg::BCDALU_IDLE;
			bcdalu_pkg::BCDALU_RUN: state_nxt = bcdalu_pkg::BCDALU_IDLE;
			default: state_nxt = bcdalu_pkg::BCDALU_IDLE;
		endcase
	end

	always_ff @(posedge CLK_I or posedge RST_I) begin
		if (RST_I) begin
			state_r <= bcdalu_pkg::BCDALU_IDLE;
			prev_exec_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			if (go_w) begin
				prev_exec_r <= exec_r;
			end
		end
	end

	// ==========================================================
	// Arithmetic
	logic [13:0] a_bin, b_bin, sub_bin, quo_w, rem_w;
	logic [14:0] dif_w;
	logic [26:0] prod_w, conv_w;
	logic [31:0] big_bcd;
	logic [15:0] rem_bcd;
	logic neg_w, is_arith, ptr_bad, dest_bad, fault_w, ok_w, zero_w;

	assign a_bin = bcd2bin(opa_r);
	assign b_bin = bcd2bin(opb_r);
	// Bias keeps the difference non-negative; the top digit is dropped below
	assign dif_w = `BCDALU_SUB_BIAS + {1'b0, a_bin} - {1'b0, b_bin}
		- {14'h0000, carry_r};
	assign neg_w = {1'b0, a_bin} < ({1'b0, b_bin} + {14'h0000, carry_r});
	assign sub_bin = neg_w ? dif_w[13:0]
		: 14'(dif_w - `BCDALU_SUB_BIAS);
	assign prod_w = 27'(a_bin) * 27'(b_bin);
	assign quo_w = (b_bin == 14'h0000) ? 14'h0000 : a_bin / b_bin;
	assign rem_w = (b_bin == 14'h0000) ? 14'h0000 : a_bin % b_bin;

	always_comb begin
		case (op_r)
			bcdalu_pkg::BCDALU_SUB: conv_w = 27'(sub_bin);
			bcdalu_pkg::BCDALU_MUL: conv_w = prod_w;
			default: conv_w = 27'(quo_w);
		endcase
	end

	bcdalu_b2d #(.BITS(27), .DIGITS(8)) u_main (
		.bin_i(conv_w),
		.bcd_o(big_bcd)
	);

	bcdalu_b2d #(.BITS(14), .DIGITS(4)) u_rem (
		.bin_i(rem_w),
		.bcd_o(rem_bcd)
	);

	assign is_arith = (op_r == bcdalu_pkg::BCDALU_SUB) | (op_r == bcdalu_pkg::BCDALU_MUL)
		| (op_r == bcdalu_pkg::BCDALU_DIV);
	assign ptr_bad = (inda_r & ~(is_bcd(ptra_r) & (bcd2bin(ptra_r) < DM_WORDS)))
		| (indb_r & ~(is_bcd(ptrb_r) & (bcd2bin(ptrb_r) < DM_WORDS)));
	assign dest_bad = (area_r == bcdalu_pkg::BCDALU_A_SYS) | (area_r == bcdalu_pkg::BCDALU_A_TIM)
		| (area_r == bcdalu_pkg::BCDALU_A_IMM);
	assign fault_w = ~is_bcd(opa_r) | ~is_bcd(opb_r) | ptr_bad | dest_bad
		| ((op_r == bcdalu_pkg::BCDALU_DIV) & (b_bin == 14'h0000));
	assign ok_w = run_w & is_arith & ~fault_w;

	always_comb begin
		case (op_r)
			bcdalu_pkg::BCDALU_SUB: zero_w = (sub_bin == 14'h0000);
			bcdalu_pkg::BCDALU_MUL: zero_w = (prod_w == 27'h0000000);
			default: zero_w = (quo_w == 14'h0000);
		endcase
	end

	// ==========================================================
	// Flags; a faulting operation leaves carry and zero alone
	always_ff @(posedge CLK_I or posedge RST_I) begin
		if (RST_I) begin
			carry_r <= 1'b0;
			fault_r <= 1'b0;
			zero_r <= 1'b0;
		end else if (run_w) begin
			case (op_r)
				bcdalu_pkg::BCDALU_CLC: carry_r <= 1'b0;
				bcdalu_pkg::BCDALU_STC: carry_r <= 1'b1;
				bcdalu_pkg::BCDALU_SUB, bcdalu_pkg::BCDALU_MUL,
				bcdalu_pkg::BCDALU_DIV: begin
					fault_r <= fault_w;
					if (!fault_w) begin
						zero_r <= zero_w;
						if (op_r == bcdalu_pkg::BCDALU_SUB) begin
							carry_r <= neg_w;
						end else if (op_r == bcdalu_pkg::BCDALU_MUL) begin
							carry_r <= carry_r | (prod_w >= `BCDALU_MUL_LIMIT);
						end
					end
				end
				default: ;
			endcase
		end
	end

	// ==========================================================
	// Result words
	always_ff @(posedge CLK_I or posedge RST_I) begin
		if (RST_I) begin
			res0_r <= `BCDALU_WORD_RST;
			res1_r <= `BCDALU_WORD_RST;
			we_r <= 1'b0;
			two_r <= 1'b0;
			res_area_r <= 3'h0;
		end else begin
			we_r <= ok_w;
			if (ok_w) begin
				res_area_r <= area_r;
				res0_r <= big_bcd[15:0];
				two_r <= (op_r != bcdalu_pkg::BCDALU_SUB);
				if (op_r == bcdalu_pkg::BCDALU_MUL) begin
					res1_r <= big_bcd[31:16];
				end else if (op_r == bcdalu_pkg::BCDALU_DIV) begin
					res1_r <= rem_bcd;
				end
			end
		end
	end

	assign PRDATA_O = prdata_r;
	assign PREADY_O = pready_r;
	assign PSLVERR_O = pslverr_r;
	assign RES_WE_O = we_r;
	assign RES_TWO_O = two_r;
	assign RES_AREA_O = res_area_r;
	assign RES_LO_O = res0_r;
	assign RES_HI_O = res1_r;
	assign CARRY_O = carry_r;
	assign FAULT_O = fault_r;
	assign ZERO_O = zero_r;

	// ==========================================================
	// Checks
	logic sub_ok_w;
	assign sub_ok_w = ok_w & (op_r == bcdalu_pkg::BCDALU_SUB);

	sub_carry_a: assert property (@(posedge CLK_I) disable iff (RST_I)
		sub_ok_w |=> carry_r == ($past(a_bin) < $past(b_bin) + 14'($past(carry_r))))
		else $error("carry after subtract wrong");
	sub_value_a: assert property (@(posedge CLK_I) disable iff (RST_I)
		sub_ok_w && !neg_w |=> bcd2bin(res0_r) + $past(b_bin)
			+ 14'($past(carry_r)) == $past(a_bin))
		else $error("non-negative difference wrong");
	sub_comp_a: assert property (@(posedge CLK_I) disable iff (RST_I)
		sub_ok_w && neg_w |=> carry_r && 15'(bcd2bin(res0_r)) + 15'($past(b_bin))
			+ 15'($past(carry_r)) == `BCDALU_SUB_BIAS + 15'($past(a_bin)))
		else $error("ten's complement result wrong");
	bad_digit_a: assert property (@(posedge CLK_I) disable iff (RST_I)
		run_w && is_arith && !is_bcd(opa_r) |=> fault_r && !we_r)
		else $error("bad digit not faulted");
	ptr_fault_a: assert property (@(posedge CLK_I) disable iff (RST_I)
		run_w && is_arith && ptr_bad |=> fault_r && !we_r)
		else $error("bad pointer not faulted");
	diff_once_a: assert property (@(posedge CLK_I) disable iff (RST_I)
		go_w && diff_r && prev_exec_r |=> !we_r && $stable(res0_r))
		else $error("differentiated op repeated");
	idle_cond_a: assert property (@(posedge CLK_I) disable iff (RST_I)
		go_w && !exec_r |=> !we_r && $stable(fault_r) && $stable(carry_r))
		else $error("disabled op had an effect");
	mul_word_a: assert property (@(posedge CLK_I) disable iff (RST_I)
		ok_w && op_r == bcdalu_pkg::BCDALU_MUL |=> two_r
			&& 27'(bcd2bin(res1_r)) * 27'd10000 + 27'(bcd2bin(res0_r)) == $past(prod_w))
		else $error("product words wrong");
	div_pair_a: assert property (@(posedge CLK_I) disable iff (RST_I)
		ok_w && op_r == bcdalu_pkg::BCDALU_DIV |=> bcd2bin(res1_r) < $past(b_bin)
			&& bcd2bin(res0_r) * $past(b_bin) + bcd2bin(res1_r) == $past(a_bin))
		else $error("quotient or remainder wrong");
	div_zero_a: assert property (@(posedge CLK_I) disable iff (RST_I)
		run_w && op_r == bcdalu_pkg::BCDALU_DIV && opb_r == 16'h0000
			|=> fault_r && $stable(res0_r) && $stable(res1_r))
		else $error("zero divisor not refused");
	dest_area_a: assert property (@(posedge CLK_I) disable iff (RST_I)
		we_r |-> res_area_r != 3'h1 && res_area_r != 3'h5 && res_area_r != 3'h7)
		else $error("result written to protected area");

endmodule : bcdalu_top

// ==== bcdalu_seq_model.sv ====
// Sequencer model: issues APB transfers toward the decimal unit
`timescale 1ns/1ps

module bcdalu_seq_model (
	// Clock
	input wire logic clk_i,
	// APB master side
	output logic psel_o,
	output logic penable_o,
	output logic pwrite_o,
	output logic [7:0] paddr_o,
	output logic [31:0] pwdata_o,
	// APB answer
	input wire logic [31:0] prdata_i,
	input wire logic pready_i,
	input wire logic pslverr_i
);
	initial begin
		psel_o = 1'b0;
		penable_o = 1'b0;
		pwrite_o = 1'b0;
		paddr_o = 8'h00;
		pwdata_o = 32'h00000000;
	end

	// ==========================================================
	// One transfer
	// Waits one edge first so a released strobe is never raised in the same step
	task automatic xfer(input logic wr, input logic [7:0] ad, input logic [31:0] wd,
			output logic [31:0] rd, output logic err);
		@(posedge clk_i);
		psel_o <= 1'b1;
		penable_o <= 1'b0;
		pwrite_o <= wr;
		paddr_o <= ad;
		pwdata_o <= wd;
		@(posedge clk_i);
		penable_o <= 1'b1;
		do begin
			@(posedge clk_i);
		end while (pready_i !== 1'b1);
		rd = prdata_i;
		err = pslverr_i;
		psel_o <= 1'b0;
		penable_o <= 1'b0;
		// Stale data must not look valid once released
		pwdata_o <= ~wd;
	endtask : xfer
endmodule : bcdalu_seq_model

// ==== bcdalu_tb_top.sv ====
// Self-checking bench for the decimal subtract, multiply and divide unit
`timescale 1ns/1ps
`include "bcdalu_params.svh"

module bcdalu_tb_top;
	// Small data-memory size so the pointer boundary is cheap to reach
	localparam int DMW = 200;
	logic clk;
	logic rst;
	logic psel, penable, pwrite, pready, pslverr;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, d;
	logic res_we, res_two, carry, fault, zero, e;
	logic [2:0] res_area;
	logic [15:0] res_lo, res_hi;
	logic [2:0] ok_area [5] = '{3'h0, 3'h2, 3'h3, 3'h4, 3'h6};
	int n_mismatch = 0;
	int comparisons = 0;
	int cyc = 0;
	int we_cnt = 0;
	int cy_m = 0, er_m = 0, eq_m = 0, lo_m = 0, hi_m = 0, two_m = 0, area_m = 0;
	int pe_m = 0, we_m = 0;

	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	bcdalu_seq_model u_seq (.clk_i(clk), .psel_o(psel), .penable_o(penable),
		.pwrite_o(pwrite), .paddr_o(paddr), .pwdata_o(pwdata), .prdata_i(prdata),
		.pready_i(pready), .pslverr_i(pslverr));

	bcdalu_top #(.DM_WORDS(14'(DMW))) DUT (.CLK_I(clk), .RST_I(rst), .PSEL_I(psel),
		.PENABLE_I(penable), .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata),
		.PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr), .RES_WE_O(res_we),
		.RES_TWO_O(res_two), .RES_AREA_O(res_area), .RES_LO_O(res_lo),
		.RES_HI_O(res_hi), .CARRY_O(carry), .FAULT_O(fault), .ZERO_O(zero));

	// ==========================================================
	// Helpers
	function automatic int b2i(input logic [15:0] w);
		return w[15:12] * 1000 + w[11:8] * 100 + w[7:4] * 10 + w[3:0];
	endfunction : b2i

	function automatic logic [15:0] i2b(input int v);
		return {4'(v / 1000 % 10), 4'(v / 100 % 10), 4'(v / 10 % 10), 4'(v % 10)};
	endfunction : i2b

	function automatic logic isbcd(input logic [15:0] w);
		return w[15:12] < 10 && w[11:8] < 10 && w[7:4] < 10 && w[3:0] < 10;
	endfunction : isbcd

	task automatic final_report();
		$display("Comparisons %0d, mismatches %0d", comparisons, n_mismatch);
		if (n_mismatch == 0 && comparisons > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : final_report

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			n_mismatch++;
			$display("MISMATCH at %0t: got %0h expected %0h", $time, got, exp);
		end
	endtask : chk

	task automatic wr(input logic [7:0] ad, input logic [15:0] dat);
		logic [31:0] rd;
		logic er;
		u_seq.xfer(1'b1, ad, {16'hA5A5, dat}, rd, er);
	endtask : wr

	// ==========================================================
	// One scan of an operation, with the reference model beside it
	task automatic op(input logic [15:0] a, input logic [15:0] b, input logic [2:0] o,
			input logic [2:0] ar = 3'h0, input logic ex = 1'b1, input logic df = 1'b0,
			input logic ia = 1'b0, input logic ib = 1'b0,
			input logic [15:0] pa = 16'h0000, input logic [15:0] pb = 16'h0000);
		int av;
		int bv;
		logic run;
		logic ok;
		av = b2i(a);
		bv = b2i(b);
		wr(`BCDALU_OFF_OPA, a);
		wr(`BCDALU_OFF_OPB, b);
		wr(`BCDALU_OFF_PTRA, pa);
		wr(`BCDALU_OFF_PTRB, pb);
		wr(`BCDALU_OFF_CMD, {6'h00, ib, ia, ar, ex, df, o});
		repeat (4) @(posedge clk);
		run = ex && !(df && pe_m != 0);
		pe_m = ex;
		ok = isbcd(a) && isbcd(b) && !(ar inside {3'h1, 3'h5, 3'h7}) && !(o == 3'h3 && bv == 0)
			&& !(ia && !(isbcd(pa) && b2i(pa) < DMW)) && !(ib && !(isbcd(pb) && b2i(pb) < DMW));
		if (run && o == 3'h4)
			cy_m = 0;
		if (run && o == 3'h5)
			cy_m = 1;
		if (run && o inside {3'h1, 3'h2, 3'h3}) begin
			er_m = !ok;
			if (ok) begin
				we_m++;
				two_m = (o != 3'h1);
				area_m = ar;
				case (o)
					3'h1: begin
						lo_m = (10000 + av - bv - cy_m) % 10000;
						cy_m = (av < bv + cy_m);
					end
					3'h2: begin
						lo_m = av * bv % 10000;
						hi_m = av * bv / 10000;
					end
					default: begin
						lo_m = av / bv;
						hi_m = av % bv;
					end
				endcase
				eq_m = (lo_m == 0) && (o != 3'h2 || hi_m == 0);
			end
		end
		chk(we_cnt, we_m);
		chk(res_lo, i2b(lo_m));
		chk(res_hi, i2b(hi_m));
		chk(carry, cy_m);
		chk(fault, er_m);
		chk(zero, eq_m);
		chk({res_two, res_area}, {two_m[0], area_m[2:0]});
	endtask : op

	always @(posedge clk) begin
		cyc++;
		if (res_we === 1'b1)
			we_cnt++;
		if (cyc == 30000) begin
			n_mismatch++;
			final_report();
		end
	end

	// ==========================================================
	// Tests
	initial begin
		rst = 1'b1;
		void'($urandom(80));
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		op(16'h0000, 16'h0000, 3'h4);
		op(16'h1029, 16'h3452, 3'h1, 3'h4);
		op(16'h0000, 16'h0000, 3'h4);
		op(16'h0000, 16'h7577, 3'h1, 3'h4);
		op(16'h0000, 16'h0000, 3'h5);
		op(16'h0000, 16'h9999, 3'h1);
		op(16'h3356, 16'h0025, 3'h2, 3'h4);
		op(16'h9999, 16'h9999, 3'h2);
		op(16'h3452, 16'h0003, 3'h3, 3'h3);
		op(16'h0002, 16'h0003, 3'h3);
		op(16'h0000, 16'h1234, 3'h2);
		$display("Test fixed cases done");
		for (int i = 0; i < 40; i++) begin
			if ($urandom_range(1) == 1)
				op(16'h0000, 16'h0000, 3'($urandom_range(5, 4)));
			op(i2b($urandom_range(9999)), i2b($urandom_range(9999)), 3'($urandom_range(3, 1)),
				ok_area[$urandom_range(4)]);
		end
		$display("Test random operations done");
		for (int o = 1; o < 4; o++) begin
			op(16'h00A0, 16'h0001, 3'(o));
			op(16'h0001, 16'h100F, 3'(o));
			op(16'h0005, 16'h0002, 3'(o), 3'h0, 1'b1, 1'b0, 1'b1, 1'b0, 16'h0200);
			op(16'h0005, 16'h0002, 3'(o), 3'h0, 1'b1, 1'b0, 1'b0, 1'b1, 16'h0, 16'h01A0);
			op(16'h0005, 16'h0002, 3'(o), 3'h0, 1'b1, 1'b0, 1'b1, 1'b1, 16'h0199);
		end
		op(16'h4321, 16'h0000, 3'h3);
		for (int ar = 0; ar < 8; ar++)
			op(16'h0042, 16'h0017, 3'h1, 3'(ar));
		$display("Test faults done");
		op(16'h0010, 16'h0002, 3'h3, 3'h0, 1'b0);
		op(16'h0008, 16'h0002, 3'h3, 3'h0, 1'b1, 1'b1);
		op(16'h0009, 16'h0002, 3'h3, 3'h0, 1'b1, 1'b1);
		op(16'h0009, 16'h0002, 3'h3);
		$display("Test conditions done");
		u_seq.xfer(1'b0, `BCDALU_OFF_STAT, 32'h0, d, e);
		chk(d, {`BCDALU_CARRY_ADDR, 13'h0000, eq_m[0], er_m[0], cy_m[0]});
		u_seq.xfer(1'b0, `BCDALU_OFF_RES0, 32'h0, d, e);
		chk(d, {16'h0000, i2b(lo_m)});
		u_seq.xfer(1'b0, `BCDALU_OFF_RES1, 32'h0, d, e);
		chk(d, {16'h0000, i2b(hi_m)});
		u_seq.xfer(1'b0, 8'h20, 32'h0, d, e);
		chk({d[30:0], e}, 32'h00000001);
		$display("Test registers done");
		final_report();
	end
endmodule : bcdalu_tb_top
